/* verilog/cwdt_core_watchdog.sv */
// Core watchdog timer: counter, service key logic, control, reset cause,
// event status and mask registers, and the forced transfer acknowledge.
// Assumes one 200 MHz clock, a synchronous active-high reset and a bus
// master that never issues read and write strobes in the same cycle.
//
// Functional notes
// - Counting happens only while enabled; enable is cleared by reset.
// - Select bit 0: timeout raises an interrupt request to the core.
// - Select bit 1: timeout requests a soft reset of the device.
// - Reset timeout pulses internal reset and sets the watchdog cause flag.
// - Any accesses may occur between the two key writes.
// - A completed key pair restarts the counter from zero.
// - Period select 000..111 gives 2^9,11,13,15,19,23,27,31 bus clocks.
// - Ack enabled, interrupt unacknowledged another period: force transfer ack.
// - Forced ack sets the ack-occurred flag; writing 1 clears it.
// - Timeout interrupt sets the irq flag; writing 1 clears the request.
// - Control is always readable; config writes ignored while timeout pending.
// - Service writes do not negate a pending watchdog interrupt.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

module cwdt_core_watchdog
#(
  parameter logic [39:0] PERIOD_EXP = cwdt_pkg::CWDT_PERIOD_EXP_DEFAULT
)
(
  input wire logic mclk, // 200 MHz clock
  input wire logic reset, // synchronous reset, active high
  input wire cwdt_pkg::cwdt_bus_t bus_req, // register port request
  output logic [7:0] bus_rdata, // read data, one cycle after read
  output logic watchdog_irq, // interrupt request to the core
  output logic transfer_acknowledge, // forced bus cycle end, pulse
  output logic soft_reset, // device soft reset request, pulse
  output logic irq // masked event interrupt, level
);
  import cwdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Decode and register state.

  // Exponents come from a parameter so that a bench can shorten the
  // periods without touching the counter or the compare logic.
  function automatic logic [31:0] period_last(input logic [2:0] sel);
    logic [4:0] exp_val;
    exp_val = PERIOD_EXP[5*sel +: 5];
    period_last = (32'h1 << exp_val) - 32'h1;
  endfunction

  logic [7:0] watchdog_control;
  logic [7:0] core_reset_cause;
  logic [CWDT_EVT_WIDTH-1:0] evt_status;
  logic [CWDT_EVT_WIDTH-1:0] evt_mask;
  logic [31:0] count;
  cwdt_key_state_t key_state;

  logic watchdog_enable;
  logic reset_or_irq_select;
  logic [2:0] timeout_period_select;
  logic forced_ack_enable;
  logic forced_ack_occurred;
  logic watchdog_irq_flag;
  logic wr_ctrl;
  logic wr_service;
  logic wr_cause;
  logic wr_status;
  logic wr_mask;
  logic expire;
  logic timeout_irq;
  logic timeout_reset;
  logic force_ack;
  logic service_done;
  logic [CWDT_EVT_WIDTH-1:0] evt_set;

  assign watchdog_enable = watchdog_control[CWDT_ENABLE_BIT];
  assign reset_or_irq_select = watchdog_control[CWDT_RSEL_BIT];
  assign timeout_period_select =
    watchdog_control[CWDT_PERIOD_MSB:CWDT_PERIOD_LSB];
  assign forced_ack_enable = watchdog_control[CWDT_ACK_EN_BIT];
  assign forced_ack_occurred = watchdog_control[CWDT_ACK_OCC_BIT];
  assign watchdog_irq_flag = watchdog_control[CWDT_IRQ_FLAG_BIT];

  assign wr_ctrl = bus_req.wr && (bus_req.addr == CWDT_CTRL_ADDR);
  assign wr_service = bus_req.wr && (bus_req.addr == CWDT_SERVICE_ADDR);
  assign wr_cause = bus_req.wr && (bus_req.addr == CWDT_CAUSE_ADDR);
  assign wr_status = bus_req.wr && (bus_req.addr == CWDT_EVT_STATUS_ADDR);
  assign wr_mask = bus_req.wr && (bus_req.addr == CWDT_EVT_MASK_ADDR);

  ////////////////////////////////////////////////////////////////////////
  // Timeout detection.

  // The count reaches the selected period after exactly that many
  // enabled clocks, then restarts so a second period can be timed.
  assign expire = watchdog_enable &&
    (count == period_last(timeout_period_select));
  assign timeout_irq = expire && !reset_or_irq_select &&
    !watchdog_irq_flag;
  assign timeout_reset = expire && reset_or_irq_select;
  // A second expiry with the request still standing ends the bus cycle.
  assign force_ack = expire && !reset_or_irq_select && watchdog_irq_flag &&
    forced_ack_enable;

  // Service is refused while a timeout interrupt is pending.
  assign service_done = wr_service && (bus_req.wdata == CWDT_KEY_SECOND) &&
    (key_state == CWDT_KEY_ARMED) && !watchdog_irq_flag;

  ////////////////////////////////////////////////////////////////////////
  // Service key sequence.

  always_ff @(posedge mclk)
  begin
    if (reset)
      key_state <= CWDT_KEY_IDLE;
    else if (wr_service && !watchdog_irq_flag)
    begin
      // Other values leave the sequence where it is, so unrelated
      // accesses between the two keys do not break it.
      if (bus_req.wdata == CWDT_KEY_FIRST)
        key_state <= CWDT_KEY_ARMED;
      else if (bus_req.wdata == CWDT_KEY_SECOND)
        key_state <= CWDT_KEY_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter.

  always_ff @(posedge mclk)
  begin
    if (reset)
      count <= 32'h0;
    else if (service_done || expire)
      count <= 32'h0;
    else if (watchdog_enable)
      count <= count + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register.

  always_ff @(posedge mclk)
  begin
    if (reset)
      watchdog_control <= CWDT_CTRL_RESET;
    else
    begin
      // Configuration bits change only while no timeout is pending.
      if (wr_ctrl && !watchdog_irq_flag)
      begin
        watchdog_control[CWDT_ENABLE_BIT:CWDT_ACK_EN_BIT] <=
          bus_req.wdata[CWDT_ENABLE_BIT:CWDT_ACK_EN_BIT];
      end
      // Hardware set wins over a same-cycle write of one.
      if (force_ack)
        watchdog_control[CWDT_ACK_OCC_BIT] <= 1'b1;
      else if (wr_ctrl && bus_req.wdata[CWDT_ACK_OCC_BIT])
        watchdog_control[CWDT_ACK_OCC_BIT] <= 1'b0;
      if (timeout_irq)
        watchdog_control[CWDT_IRQ_FLAG_BIT] <= 1'b1;
      else if (wr_ctrl && bus_req.wdata[CWDT_IRQ_FLAG_BIT])
        watchdog_control[CWDT_IRQ_FLAG_BIT] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core reset cause register.

  // This register is cleared by the block reset or by writing one to the cause bit;
  // the soft reset request is expected to spare it so the cause survives.
  always_ff @(posedge mclk)
  begin
    if (reset)
      core_reset_cause <= CWDT_CAUSE_RESET;
    else if (timeout_reset)
      core_reset_cause[CWDT_CAUSE_BIT] <= 1'b1;
    else if (wr_cause && bus_req.wdata[CWDT_CAUSE_BIT])
      core_reset_cause[CWDT_CAUSE_BIT] <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Event status and mask.

  assign evt_set = {timeout_reset, force_ack, timeout_irq};

  genvar gi;
  generate
    for (gi = 0; gi < CWDT_EVT_WIDTH; gi++)
    begin : g_evt
      always_ff @(posedge mclk)
      begin
        if (reset)
          evt_status[gi] <= 1'b0;
        else if (evt_set[gi])
          evt_status[gi] <= 1'b1;
        else if (wr_status && bus_req.wdata[gi])
          evt_status[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (reset)
      evt_mask <= CWDT_EVT_RESET;
    else if (wr_mask)
      evt_mask <= bus_req.wdata[CWDT_EVT_WIDTH-1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      watchdog_irq <= 1'b0;
      transfer_acknowledge <= 1'b0;
      soft_reset <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      watchdog_irq <= timeout_irq ||
        (watchdog_irq_flag &&
         !(wr_ctrl && bus_req.wdata[CWDT_IRQ_FLAG_BIT]));
      transfer_acknowledge <= force_ack;
      soft_reset <= timeout_reset;
      irq <= |((evt_status | evt_set) & evt_mask);
    end
  end

  // Reads answer one cycle later; unmapped addresses read zero.
  always_ff @(posedge mclk)
  begin
    if (reset)
      bus_rdata <= 8'h00;
    else if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        CWDT_CTRL_ADDR: bus_rdata <= watchdog_control;
        CWDT_CAUSE_ADDR: bus_rdata <= core_reset_cause;
        CWDT_EVT_STATUS_ADDR: bus_rdata <= {5'h00, evt_status};
        CWDT_EVT_MASK_ADDR: bus_rdata <= {5'h00, evt_mask};
        default: bus_rdata <= 8'h00;
      endcase
    end
    else
      bus_rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  hold_when_off_a: assert property (
    !watchdog_enable && !service_done |=> $stable(count))
    else $error("count moved while watchdog disabled");

  irq_on_timeout_a: assert property (
    expire && !reset_or_irq_select && !watchdog_irq_flag
    |=> watchdog_irq && watchdog_irq_flag && !soft_reset)
    else $error("irq-mode timeout did not raise the request");

  reset_on_timeout_a: assert property (
    expire && reset_or_irq_select |=> soft_reset && !watchdog_irq)
    else $error("reset-mode timeout did not request soft reset");

  cause_flag_set_a: assert property (
    soft_reset |-> core_reset_cause[CWDT_CAUSE_BIT])
    else $error("soft reset without watchdog cause flag");

  key_restart_a: assert property (
    // One idle cycle between the keys, as a tight service loop issues them.
    wr_service && bus_req.wdata == CWDT_KEY_FIRST && !watchdog_irq_flag
    ##1 (!wr_service) [*1]
    ##1 wr_service && bus_req.wdata == CWDT_KEY_SECOND && !watchdog_irq_flag
    |=> count == 32'h0)
    else $error("key pair with gap did not restart the counter");

  // Four steps fit inside even a shortened period, so that the check
  // also runs when the bench narrows the exponents.
  period_cycle_a: assert property (
    watchdog_enable && count == 32'h0 && timeout_period_select == 3'h0
    && period_last(timeout_period_select) >= 32'h4
    && !service_done && !wr_ctrl ##1
    (watchdog_enable && !service_done && !wr_ctrl) [*4]
    |-> count == 32'h4)
    else $error("counter does not step once per clock");

  ack_after_second_a: assert property (
    transfer_acknowledge |-> $past(watchdog_irq_flag) &&
    $past(forced_ack_enable) && forced_ack_occurred)
    else $error("forced ack without pending interrupt");

  irq_clear_a: assert property (
    wr_ctrl && bus_req.wdata[CWDT_IRQ_FLAG_BIT] && !timeout_irq
    |=> !watchdog_irq_flag && !watchdog_irq)
    else $error("write of one did not clear the interrupt");

  cfg_locked_a: assert property (
    wr_ctrl && watchdog_irq_flag
    |=> watchdog_control[7:2] == $past(watchdog_control[7:2]))
    else $error("control written while timeout pending");

  pending_kept_a: assert property (
    watchdog_irq_flag && wr_service && !wr_ctrl |=> watchdog_irq_flag)
    else $error("service write negated a pending interrupt");

  key_frozen_a: assert property (
    watchdog_irq_flag && wr_service |=> key_state == $past(key_state))
    else $error("service write moved the key state while pending");

  // Set and clear of the acknowledge-occurred flag, seen on the internal control bit.
  ack_flag_set_a: assert property (
    force_ack |=> forced_ack_occurred)
    else $error("forced ack did not set the occurred flag");

  ack_flag_clear_a: assert property (
    wr_ctrl && bus_req.wdata[CWDT_ACK_OCC_BIT] && !force_ack
    |=> !forced_ack_occurred)
    else $error("write of one did not clear the occurred flag");

  ctrl_read_a: assert property (
    bus_req.rd && bus_req.addr == CWDT_CTRL_ADDR
    |=> bus_rdata == $past(watchdog_control))
    else $error("control read returned a wrong value");

  // Read data must fall back to zero so that a stale value is never taken.
  rdata_idle_a: assert property (
    !bus_req.rd |=> bus_rdata == 8'h00)
    else $error("read data not zero outside a read");

  count_restart_a: assert property (
    expire |=> count == 32'h0)
    else $error("counter did not restart after a timeout");

  serviced_cov: cover property (service_done);
  irq_timeout_cov: cover property (timeout_irq);
  forced_ack_cov: cover property (transfer_acknowledge);
  soft_reset_cov: cover property (soft_reset);

endmodule // cwdt_core_watchdog

/* verilog/cwdt_pkg.sv */
// Package for the core watchdog timer: register map, field layout,
// reset values, key values and the bus request carrier.
// Assumes a single 200 MHz clock and a plain register port with 8-bit data.
package cwdt_pkg;

  // Byte addresses of the registers on the plain register port.
  localparam logic [7:0] CWDT_CTRL_ADDR = 8'h00;
  localparam logic [7:0] CWDT_SERVICE_ADDR = 8'h04;
  localparam logic [7:0] CWDT_CAUSE_ADDR = 8'h08;
  localparam logic [7:0] CWDT_EVT_STATUS_ADDR = 8'h0C;
  localparam logic [7:0] CWDT_EVT_MASK_ADDR = 8'h10;

  // Field positions in the watchdog control register.
  localparam int CWDT_ENABLE_BIT = 7;
  localparam int CWDT_RSEL_BIT = 6;
  localparam int CWDT_PERIOD_LSB = 3;
  localparam int CWDT_PERIOD_MSB = 5;
  localparam int CWDT_ACK_EN_BIT = 2;
  localparam int CWDT_ACK_OCC_BIT = 1;
  localparam int CWDT_IRQ_FLAG_BIT = 0;

  // Watchdog cause bit in the core reset cause register.
  localparam int CWDT_CAUSE_BIT = 5;

  // Event bits in the status and mask registers.
  localparam int CWDT_EVT_TIMEOUT = 0;
  localparam int CWDT_EVT_FORCED_ACK = 1;
  localparam int CWDT_EVT_SOFT_RESET = 2;
  localparam int CWDT_EVT_WIDTH = 3;

  // Values after reset.
  localparam logic [7:0] CWDT_CTRL_RESET = 8'h00;
  localparam logic [7:0] CWDT_CAUSE_RESET = 8'h00;
  localparam logic [2:0] CWDT_EVT_RESET = 3'h0;

  // Service key sequence.
  localparam logic [7:0] CWDT_KEY_FIRST = 8'h55;
  localparam logic [7:0] CWDT_KEY_SECOND = 8'hAA;

  // Timeout exponents for selects 7 down to 0, five bits each.
  localparam logic [39:0] CWDT_PERIOD_EXP_DEFAULT =
    {5'h1F, 5'h1B, 5'h17, 5'h13, 5'h0F, 5'h0D, 5'h0B, 5'h09};

  typedef enum logic [0:0] {
    CWDT_KEY_IDLE = 1'b0,
    CWDT_KEY_ARMED = 1'b1
  } cwdt_key_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cwdt_bus_t;

endpackage

/* verif/cwdt_core_model.sv */
// Core-side model: counts the pulses that the watchdog sends to the core.
// Assumes registered single-cycle pulses on mclk.
`timescale 1ns/1ps

module cwdt_core_model
(
  input wire logic mclk, // bus clock
  input wire logic reset, // synchronous reset, active high
  input wire logic transfer_acknowledge, // forced bus cycle end
  input wire logic soft_reset, // device soft reset request
  output int ack_seen, // forced acknowledges seen
  output int reset_seen // soft resets seen
);
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ack_seen <= 0;
      reset_seen <= 0;
    end
    else
    begin
      ack_seen <= ack_seen + int'(transfer_acknowledge);
      reset_seen <= reset_seen + int'(soft_reset);
    end
  end
endmodule // cwdt_core_model

/* verif/cwdt_core_watchdog_bench.sv */
// Self-checking bench for the core watchdog: register port tasks and
// timed scenarios. Periods are shortened to 2^3..2^10 by parameter.
`timescale 1ns/1ps

module cwdt_core_watchdog_bench;
  import cwdt_pkg::*;
  logic mclk;
  logic reset;
  cwdt_bus_t bus_req;
  logic [7:0] bus_rdata;
  logic watchdog_irq;
  logic transfer_acknowledge;
  logic soft_reset;
  logic irq;
  int ack_seen;
  int reset_seen;
  int mismatches = 0;
  int check_count = 0;
  int n;

  cwdt_core_watchdog #(.PERIOD_EXP({5'h0A, 5'h09, 5'h08, 5'h07, 5'h06,
    5'h05, 5'h04, 5'h03})) uut (.mclk(mclk), .reset(reset),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .watchdog_irq(watchdog_irq),
    .transfer_acknowledge(transfer_acknowledge), .soft_reset(soft_reset),
    .irq(irq));

  cwdt_core_model core (.mclk(mclk), .reset(reset),
    .transfer_acknowledge(transfer_acknowledge), .soft_reset(soft_reset),
    .ack_seen(ack_seen), .reset_seen(reset_seen));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1;
    check(32'(bus_rdata), 32'(exp));
  endtask

  // Clear flags, disable, service, then load the new setting.
  task automatic restart(input logic [7:0] ctrl);
    wr(CWDT_CTRL_ADDR, 8'h03);
    wr(CWDT_CTRL_ADDR, 8'h00);
    wr(CWDT_SERVICE_ADDR, CWDT_KEY_FIRST);
    wr(CWDT_SERVICE_ADDR, CWDT_KEY_SECOND);
    wr(CWDT_CTRL_ADDR, ctrl);
  endtask

  // Counts edges until the chosen output is seen high, with a bound.
  task automatic wait_on(input int which, output int cnt);
    cnt = 0;
    while ((which == 0 ? watchdog_irq : which == 1 ? transfer_acknowledge
      : soft_reset) !== 1'b1 && cnt < 2000)
    begin
      @(posedge mclk);
      #1;
      cnt++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100us;
    mismatches++;
    give_verdict();
  end

  initial
  begin
    bus_req = '0;
    reset = 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    rd_chk(CWDT_CTRL_ADDR, CWDT_CTRL_RESET);
    rd_chk(CWDT_CAUSE_ADDR, CWDT_CAUSE_RESET);
    rd_chk(CWDT_EVT_STATUS_ADDR, 8'h00);
    rd_chk(CWDT_EVT_MASK_ADDR, 8'h00);
    rd_chk(CWDT_SERVICE_ADDR, 8'h00);
    rd_chk(8'h20, 8'h00);
    repeat (20) @(posedge mclk);
    check(32'(watchdog_irq), 0);
    for (int s = 0; s < 8; s++)
    begin
      restart({2'b10, 3'(s), 3'b000});
      check(32'(watchdog_irq), 0);
      wait_on(0, n);
      check(n, 1 << (3 + s));
      rd_chk(CWDT_CTRL_ADDR, {2'b10, 3'(s), 3'b001});
    end
    // Service pair with accesses between, late enough to matter.
    restart(8'h88);
    repeat (6) @(posedge mclk);
    wr(CWDT_SERVICE_ADDR, CWDT_KEY_FIRST);
    rd_chk(CWDT_CTRL_ADDR, 8'h88);
    wr(CWDT_SERVICE_ADDR, 8'h12);
    wr(CWDT_SERVICE_ADDR, CWDT_KEY_SECOND);
    wait_on(0, n);
    check(n, 16);
    wr(CWDT_SERVICE_ADDR, CWDT_KEY_FIRST);
    wr(CWDT_SERVICE_ADDR, CWDT_KEY_SECOND);
    check(32'(watchdog_irq), 1);
    wr(CWDT_CTRL_ADDR, 8'h00);
    rd_chk(CWDT_CTRL_ADDR, 8'h89);
    // Forced acknowledge after a further unacknowledged period.
    restart(8'h8C);
    wait_on(0, n);
    check(n, 16);
    wait_on(1, n);
    check(n, 16);
    rd_chk(CWDT_CTRL_ADDR, 8'h8F);
    check(ack_seen, 1);
    wr(CWDT_CTRL_ADDR, 8'h02);
    rd_chk(CWDT_CTRL_ADDR, 8'h8D);
    // Reset-mode timeout.
    restart(8'hC0);
    wait_on(2, n);
    check(n, 8);
    check(32'(watchdog_irq), 0);
    wr(CWDT_CTRL_ADDR, 8'h00);
    rd_chk(CWDT_CAUSE_ADDR, 8'h20);
    check(reset_seen, 1);
    // Event status, mask and interrupt line.
    rd_chk(CWDT_EVT_STATUS_ADDR, 8'h07);
    wr(CWDT_EVT_MASK_ADDR, 8'h04);
    repeat (2) @(posedge mclk);
    #1;
    check(32'(irq), 1);
    wr(CWDT_EVT_STATUS_ADDR, 8'h04);
    repeat (2) @(posedge mclk);
    #1;
    check(32'(irq), 0);
    rd_chk(CWDT_EVT_STATUS_ADDR, 8'h03);
    wr(CWDT_EVT_MASK_ADDR, 8'h00);
    wr(CWDT_EVT_STATUS_ADDR, 8'h03);
    rd_chk(CWDT_EVT_STATUS_ADDR, 8'h00);
    give_verdict();
  end
endmodule // cwdt_core_watchdog_bench
